// ==== design/flp_lock_protect.sv ====
// Function
// - Complement, bottom code protects upper region
// - Complement, bottom code 0001 spares block 0
// - Complement, top code 1011 protects lower half
// - Complement, third and fourth bits: nothing protected
// - 2078 volatile lock bytes
// - E0 reads one volatile lock byte
// - E1 writes one volatile lock byte
// - 98 clears, 7E sets all volatile bytes
// - Edge blocks per sector, middle per block
// - Reset loads volatile bytes from default bit
// - 00 unlocked, FF locked
// - Bad volatile data ignored, latch kept
// - 2078 nonvolatile lock bytes kept over reset
// - E2 reads one nonvolatile lock byte
// - E3 sets one nonvolatile lock byte
// - E4 clears all nonvolatile bytes
// - Nonvolatile granularity same as volatile
// - Nonvolatile bytes start as 00
// - Nonvolatile FF blocks program and erase
// - Range, volatile, nonvolatile combined by OR
// - Hardware protect refuses protect and nonvolatile writes
// - Whole-array erase only when nothing protected
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module flp_lock_protect
    import flp_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire flp_cmd_t     cmd,
    output logic              cmd_ready,
    output flp_resp_t         resp,
    input  wire flp_chk_t     chk,
    output logic              chk_ready,
    output flp_chk_res_t      chk_result,
    input  wire logic         write_enable_latch,
    output logic              wel_clear,
    input  wire logic         protect_field_bit4,
    input  wire logic         protect_field_bit3,
    input  wire logic         protect_field_bit2,
    input  wire logic         protect_field_bit1,
    input  wire logic         protect_field_bit0,
    input  wire logic         protect_complement,
    input  wire logic         register_protect_first,
    input  wire logic         write_protect_n,
    input  wire logic         lock_default,
    input  wire logic         factory_init,
    output logic              status_write_allowed
);

    typedef enum logic [1:0] {
        FLP_ST_IDLE,
        FLP_ST_READ,
        FLP_ST_CHECK
    } flp_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Lock index of an address: edge blocks per sector
    function automatic logic [`FLP_INDEX_W-1:0] lock_index(
        input logic [`FLP_ADDR_W-1:0] addr
    );
        logic [`FLP_BLOCK_W-1:0]  blk;
        logic [`FLP_SECTOR_W-1:0] sec;
        blk = addr[`FLP_BLOCK_LSB +: `FLP_BLOCK_W];
        sec = addr[`FLP_SECTOR_LSB +: `FLP_SECTOR_W];
        if (blk == `FLP_BLOCK_W'(0))
            lock_index = {8'h00, sec};
        else if (blk == `FLP_LAST_BLOCK)
            lock_index = `FLP_TOP_BASE + {8'h00, sec};
        else
            lock_index = `FLP_MIDDLE_BASE + {1'b0, blk};
    endfunction

    // True when the address lies in a sector-locked edge block
    function automatic logic edge_block(
        input logic [`FLP_ADDR_W-1:0] addr
    );
        logic [`FLP_BLOCK_W-1:0] blk;
        blk = addr[`FLP_BLOCK_LSB +: `FLP_BLOCK_W];
        edge_block = (blk == `FLP_BLOCK_W'(0)) || (blk == `FLP_LAST_BLOCK);
    endfunction

    flp_state_t              state;
    flp_state_t              next_state;
    logic [`FLP_INDEX_W-1:0] scan_index;
    logic [`FLP_SECTOR_W-1:0] scan_left;
    logic [`FLP_BLOCK_W-1:0] chk_block;
    logic                    scan_hit;
    logic                    read_nonvolatile;
    logic [`FLP_INDEX_W-1:0] rd_index;
    logic                    vl_bit;
    logic                    nl_bit;
    logic                    vl_any;
    logic                    nl_any;
    logic                    range_hit;
    logic                    range_any;
    logic                    hw_protect;
    logic                    take_cmd;
    logic                    take_chk;
    logic                    data_valid;
    logic                    vl_wr_en;
    logic                    vl_fill_en;
    logic                    vl_fill_bit;
    logic                    nl_wr_en;
    logic                    nl_fill_en;
    logic                    cmd_done;
    logic                    cmd_refused;
    logic                    entry_hit;

    ////////////////////////////////////////////////////////////////////////
    // Lock storage and range decode
    flp_lock_mem u_volatile_lock (
        .clock      (clock),
        .rst_n      (rst_n),
        .reset_load (1'b1),
        .reset_bit  (lock_default),
        .wr_en      (vl_wr_en),
        .wr_index   (lock_index(cmd.addr)),
        .wr_bit     (cmd.data[0]),
        .fill_en    (vl_fill_en),
        .fill_bit   (vl_fill_bit),
        .rd_index   (rd_index),
        .rd_bit     (vl_bit),
        .any_set    (vl_any)
    );

    flp_lock_mem u_nonvolatile_lock (
        .clock      (clock),
        .rst_n      (rst_n),
        .reset_load (1'b0),
        .reset_bit  (1'b0),
        .wr_en      (nl_wr_en),
        .wr_index   (lock_index(cmd.addr)),
        .wr_bit     (1'b1),
        .fill_en    (nl_fill_en),
        .fill_bit   (1'b0),
        .rd_index   (rd_index),
        .rd_bit     (nl_bit),
        .any_set    (nl_any)
    );

    flp_range_decode u_range (
        .protect_field      ({protect_field_bit4, protect_field_bit3,
                              protect_field_bit2, protect_field_bit1,
                              protect_field_bit0}),
        .protect_complement (protect_complement),
        .block              (chk_block),
        .block_hit          (range_hit),
        .any_hit            (range_any)
    );

    ////////////////////////////////////////////////////////////////////////
    // Hardware protect mode and request acceptance
    assign hw_protect           = register_protect_first & ~write_protect_n;
    assign status_write_allowed = ~hw_protect;
    assign cmd_ready = (state == FLP_ST_IDLE);
    assign chk_ready = (state == FLP_ST_IDLE) && !cmd.valid;
    assign take_cmd  = cmd_ready && cmd.valid;
    assign take_chk  = chk_ready && chk.valid;
    assign data_valid = (cmd.data == `FLP_LOCK_OPEN) ||
                        (cmd.data == `FLP_LOCK_SHUT);

    ////////////////////////////////////////////////////////////////////////
    // Command decode: writes act in the accepting cycle
    always_comb
    begin
        vl_wr_en    = 1'b0;
        vl_fill_en  = 1'b0;
        vl_fill_bit = 1'b0;
        nl_wr_en    = 1'b0;
        nl_fill_en  = factory_init;
        cmd_done    = 1'b0;
        cmd_refused = 1'b0;
        if (take_cmd)
        begin
            case (cmd.opcode)
                `FLP_OP_WRITE_VOLATILE:
                begin
                    vl_wr_en    = write_enable_latch && data_valid;
                    cmd_done    = vl_wr_en;
                    cmd_refused = !vl_wr_en;
                end
                `FLP_OP_CLEAR_VOLATILE, `FLP_OP_SET_VOLATILE:
                begin
                    vl_fill_en  = write_enable_latch;
                    vl_fill_bit = (cmd.opcode == `FLP_OP_SET_VOLATILE);
                    cmd_done    = vl_fill_en;
                    cmd_refused = !vl_fill_en;
                end
                `FLP_OP_SET_NONVOLATILE:
                begin
                    nl_wr_en    = write_enable_latch && !hw_protect;
                    cmd_done    = nl_wr_en;
                    cmd_refused = !nl_wr_en;
                end
                `FLP_OP_CLEAR_NONVOLATILE:
                begin
                    nl_fill_en  = write_enable_latch && !hw_protect;
                    cmd_done    = nl_fill_en;
                    cmd_refused = !nl_fill_en;
                end
                `FLP_OP_READ_VOLATILE, `FLP_OP_READ_NONVOLATILE:
                    cmd_refused = 1'b0;
                default:
                    cmd_refused = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read index: request address in idle, next entry while scanning
    always_comb
    begin
        if (state != FLP_ST_IDLE)
            rd_index = scan_index + `FLP_INDEX_W'(1);
        else if (!take_chk)
            rd_index = lock_index(cmd.addr);
        else if (chk.kind == FLP_CHK_BLOCK_ERASE && edge_block(chk.addr))
            // Edge block erase scans from its first sector
            rd_index = lock_index({chk.addr[`FLP_ADDR_W-1:16], 16'h0000});
        else
            rd_index = lock_index(chk.addr);
    end

    // Combined protection of the entry read last cycle
    assign entry_hit = vl_bit | nl_bit;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            FLP_ST_IDLE:
            begin
                if (take_cmd && (cmd.opcode == `FLP_OP_READ_VOLATILE ||
                                 cmd.opcode == `FLP_OP_READ_NONVOLATILE))
                    next_state = FLP_ST_READ;
                else if (take_chk && chk.kind != FLP_CHK_CHIP_ERASE)
                    next_state = FLP_ST_CHECK;
            end
            FLP_ST_READ:
                next_state = FLP_ST_IDLE;
            FLP_ST_CHECK:
            begin
                if (scan_left == `FLP_SECTOR_W'(0))
                    next_state = FLP_ST_IDLE;
            end
            default:
                next_state = FLP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= FLP_ST_IDLE;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan bookkeeping for protection checks
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            scan_index       <= '0;
            scan_left        <= '0;
            scan_hit         <= 1'b0;
            chk_block        <= '0;
            read_nonvolatile <= 1'b0;
        end
        else if (state == FLP_ST_IDLE)
        begin
            scan_index       <= rd_index;
            scan_hit         <= 1'b0;
            read_nonvolatile <= (cmd.opcode == `FLP_OP_READ_NONVOLATILE);
            if (take_chk)
            begin
                chk_block <= chk.addr[`FLP_BLOCK_LSB +: `FLP_BLOCK_W];
                // Block erase of an edge block checks all its sectors
                if (chk.kind == FLP_CHK_BLOCK_ERASE && edge_block(chk.addr))
                    scan_left  <= `FLP_SECTORS_LAST;
                else
                    scan_left  <= '0;
            end
        end
        else if (state == FLP_ST_CHECK)
        begin
            scan_index <= rd_index;
            scan_left  <= scan_left - `FLP_SECTOR_W'(1);
            scan_hit   <= scan_hit | entry_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Check results
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            chk_result <= '0;
        else if (take_chk && chk.kind == FLP_CHK_CHIP_ERASE)
        begin
            chk_result.done    <= 1'b1;
            chk_result.allowed <= !(vl_any | nl_any | range_any);
        end
        else if (state == FLP_ST_CHECK && scan_left == `FLP_SECTOR_W'(0))
        begin
            chk_result.done    <= 1'b1;
            chk_result.allowed <= !(scan_hit | entry_hit | range_hit);
        end
        else
        begin
            chk_result.done    <= 1'b0;
            chk_result.allowed <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command answers and write latch clear
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            resp      <= '0;
            wel_clear <= 1'b0;
        end
        else
        begin
            resp.done    <= cmd_done;
            resp.refused <= cmd_refused;
            wel_clear    <= cmd_done;
            resp.valid   <= (state == FLP_ST_READ);
            if (state == FLP_ST_READ)
                resp.data <= (read_nonvolatile ? nl_bit : vl_bit) ?
                             `FLP_LOCK_SHUT : `FLP_LOCK_OPEN;
        end
    end

endmodule // flp_lock_protect

`default_nettype wire

// ==== include/flp_map.svh ====
`ifndef FLP_MAP_SVH
`define FLP_MAP_SVH

// Lock command opcodes
`define FLP_OP_READ_VOLATILE      8'hE0
`define FLP_OP_WRITE_VOLATILE     8'hE1
`define FLP_OP_CLEAR_VOLATILE     8'h98
`define FLP_OP_SET_VOLATILE       8'h7E
`define FLP_OP_READ_NONVOLATILE   8'hE2
`define FLP_OP_SET_NONVOLATILE    8'hE3
`define FLP_OP_CLEAR_NONVOLATILE  8'hE4

// Lock byte encodings
`define FLP_LOCK_OPEN             8'h00
`define FLP_LOCK_SHUT             8'hFF

// Array geometry
`define FLP_ADDR_W                27
`define FLP_BLOCK_W               11
`define FLP_BLOCK_LSB             16
`define FLP_SECTOR_LSB            12
`define FLP_SECTOR_W              4
`define FLP_LAST_BLOCK            11'h7FF
`define FLP_LOCK_COUNT            2078
`define FLP_INDEX_W               12
`define FLP_MIDDLE_BASE           12'h00F
`define FLP_TOP_BASE              12'h80E
`define FLP_SECTORS_LAST          4'hF

// Protect field layout and code limits
`define FLP_CODE_W                4
`define FLP_CODE_HALF             4'hB

`endif

// ==== include/flp_pkg.sv ====
`default_nettype none
`include "flp_map.svh"

package flp_pkg;

    typedef struct packed {
        logic                    valid;
        logic [7:0]              opcode;
        logic [`FLP_ADDR_W-1:0]  addr;
        logic [7:0]              data;
    } flp_cmd_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       done;
        logic       refused;
    } flp_resp_t;

    typedef enum logic [1:0] {
        FLP_CHK_PROGRAM,
        FLP_CHK_SECTOR_ERASE,
        FLP_CHK_BLOCK_ERASE,
        FLP_CHK_CHIP_ERASE
    } flp_chk_kind_t;

    typedef struct packed {
        logic                    valid;
        flp_chk_kind_t           kind;
        logic [`FLP_ADDR_W-1:0]  addr;
    } flp_chk_t;

    typedef struct packed {
        logic done;
        logic allowed;
    } flp_chk_res_t;

endpackage

`default_nettype wire

// ==== design/flp_lock_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module flp_lock_mem
    import flp_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    reset_load,
    input  wire logic                    reset_bit,
    input  wire logic                    wr_en,
    input  wire logic [`FLP_INDEX_W-1:0] wr_index,
    input  wire logic                    wr_bit,
    input  wire logic                    fill_en,
    input  wire logic                    fill_bit,
    input  wire logic [`FLP_INDEX_W-1:0] rd_index,
    output logic                         rd_bit,
    output logic                         any_set
);

    // Each lock byte is 00 or FF, so one bit per entry
    logic [`FLP_LOCK_COUNT-1:0] locks;

    ////////////////////////////////////////////////////////////////////////
    // Storage; reset load only where the contents are volatile
    genvar g;
    generate
        for (g = 0; g < `FLP_LOCK_COUNT; g = g + 1)
        begin : g_entry
            always_ff @(posedge clock)
            begin
                if (!rst_n && reset_load)
                    locks[g] <= reset_bit;
                else if (fill_en)
                    locks[g] <= fill_bit;
                else if (wr_en && wr_index == `FLP_INDEX_W'(g))
                    locks[g] <= wr_bit;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Registered read port
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rd_bit <= 1'b0;
        else
            rd_bit <= locks[rd_index];
    end

    // Any entry locked, for whole-array erase
    assign any_set = |locks;

endmodule // flp_lock_mem

`default_nettype wire

// ==== design/flp_range_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module flp_range_decode
    import flp_pkg::*;
(
    input  wire logic [4:0]              protect_field,
    input  wire logic                    protect_complement,
    input  wire logic [`FLP_BLOCK_W-1:0] block,
    output logic                         block_hit,
    output logic                         any_hit
);

    logic [`FLP_CODE_W-1:0]  code;
    logic                    base_all;
    logic                    base_none;
    logic [`FLP_BLOCK_W:0]   span;
    logic                    base_hit;

    ////////////////////////////////////////////////////////////////////////
    // Plain range, then complemented when asked
    always_comb
    begin
        code      = protect_field[3:0];
        base_all  = protect_field[3] & protect_field[2];
        base_none = (code == 4'h0);
        span      = (`FLP_BLOCK_W+1)'(1) << (code - 4'h1);
        if (base_all)
            base_hit = 1'b1;
        else if (base_none)
            base_hit = 1'b0;
        else if (protect_field[4])
            base_hit = {1'b0, block} < span;
        else
            base_hit = {1'b0, block} >= ((`FLP_BLOCK_W+1)'(2048) - span);
        block_hit = protect_complement ? ~base_hit : base_hit;
        any_hit   = protect_complement ? ~base_all : ~base_none;
    end

endmodule // flp_range_decode

`default_nettype wire

// ==== tb/flp_lock_protect_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module flp_lock_protect_sva
    import flp_pkg::*;
(
    input wire logic         clock,
    input wire logic         rst_n,
    input wire flp_cmd_t     cmd,
    input wire logic         cmd_ready,
    input wire flp_resp_t    resp,
    input wire flp_chk_t     chk,
    input wire logic         chk_ready,
    input wire flp_chk_res_t chk_result,
    input wire logic         write_enable_latch,
    input wire logic         wel_clear,
    input wire logic         register_protect_first,
    input wire logic         write_protect_n,
    input wire logic         status_write_allowed
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Accepted requests and legal lock data
    logic take;
    logic ctake;
    logic good;
    assign take = cmd.valid && cmd_ready;
    assign ctake = chk.valid && chk_ready;
    assign good = cmd.data inside {8'h00, 8'hFF};

    ////////////////////////////////
    a_read_answer: assert property (take && cmd.opcode inside {8'hE0, 8'hE2}
        |=> !cmd_ready ##1 resp.valid) else $error("read answer late");
    a_write_done: assert property (take && cmd.opcode == 8'hE1
        && write_enable_latch && good |=> resp.done && wel_clear)
        else $error("lock write not done");
    a_bad_data: assert property (take && cmd.opcode == 8'hE1 && !good
        |=> resp.refused && !wel_clear) else $error("bad data taken");
    a_no_latch: assert property (take && !write_enable_latch
        && cmd.opcode inside {8'hE1, 8'h98, 8'h7E, 8'hE3, 8'hE4}
        |=> resp.refused && !resp.done) else $error("write without latch");
    a_hw_lock: assert property (take && cmd.opcode inside {8'hE3, 8'hE4}
        && register_protect_first && !write_protect_n |=> resp.refused)
        else $error("protected write taken");
    a_status_gate: assert property (status_write_allowed ==
        !(register_protect_first && !write_protect_n)) else $error("gate");
    a_read_code: assert property (resp.valid |->
        resp.data inside {8'h00, 8'hFF}) else $error("lock code");
    a_chip_check: assert property (ctake
        && chk.kind == FLP_CHK_CHIP_ERASE |=> chk_result.done)
        else $error("chip check late");
    a_prog_check: assert property (ctake && chk.kind == FLP_CHK_PROGRAM
        |=> !chk_result.done ##1 chk_result.done) else $error("program check");
    a_clear_cause: assert property (wel_clear |-> $past(take)
        && $past(write_enable_latch)) else $error("stray latch clear");
endmodule // flp_lock_protect_sva

bind flp_lock_protect flp_lock_protect_sva flp_lock_protect_sva_i (
    .clock, .rst_n, .cmd, .cmd_ready, .resp, .chk, .chk_ready, .chk_result,
    .write_enable_latch, .wel_clear, .register_protect_first,
    .write_protect_n, .status_write_allowed);
`default_nettype wire

// ==== tb/flp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module flp_host_model
    import flp_pkg::*;
(
    input  wire logic clock,
    input  wire logic cmd_ready,
    input  wire logic wel_clear,
    output flp_cmd_t  cmd,
    output logic      write_enable_latch
);
    logic set_req;
    logic set_val;

    // Idle bus at time zero
    initial
    begin
        cmd = '0;
        write_enable_latch = 1'b0;
        set_req = 1'b0;
        set_val = 1'b0;
    end

    ////////////////////////////////
    // Latch set by the host, dropped on the device pulse
    always @(posedge clock)
    begin
        if (set_req)
            write_enable_latch <= set_val;
        else if (wel_clear)
            write_enable_latch <= 1'b0;
    end

    // Write enable ahead of a write
    task automatic set_latch(input logic v);
        @(posedge clock);
        set_req <= 1'b1;
        set_val <= v;
        @(posedge clock);
        set_req <= 1'b0;
    endtask

    // Request held until taken, then fields scrambled
    task automatic send(input logic [7:0] o,
                        input logic [`FLP_ADDR_W-1:0] a,
                        input logic [7:0] d);
        logic r;
        @(posedge clock);
        cmd <= '{1'b1, o, a, d};
        do
        begin
            @(negedge clock);
            r = cmd_ready;
            @(posedge clock);
        end
        while (!r);
        cmd <= '{1'b0, ~o, ~a, ~d};
    endtask
endmodule // flp_host_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "flp_map.svh"

module tb
    import flp_pkg::*;
;
    localparam logic [10:0] rd_e = 11'h400;
    localparam logic [10:0] ff_e = 11'h4FF;
    localparam logic [10:0] dn_e = 11'h200;
    localparam logic [10:0] rf_e = 11'h100;
    logic         clock, rst_n, lock_default, factory_init;
    logic         cmpl, rpf, wp_n, cmd_ready, chk_ready;
    logic         write_enable_latch, wel_clear, status_write_allowed;
    logic [4:0]   pf;
    logic [7:0]   bad;
    flp_cmd_t     cmd;
    flp_resp_t    resp;
    flp_chk_t     chk;
    flp_chk_res_t chk_result;
    logic [10:0]  rq[$];
    logic         cq[$];
    int           b, err_total, total_checks;
    logic [16:0]  rng [8] = '{{5'h0B, 11'h3FF, 1'h0}, {5'h0B, 11'h400, 1'h1},
        {5'h11, 11'h000, 1'h1}, {5'h11, 11'h001, 1'h0},
        {5'h1B, 11'h3FF, 1'h1}, {5'h1B, 11'h400, 1'h0},
        {5'h0C, 11'h000, 1'h1}, {5'h1F, 11'h7FF, 1'h1}};

    flp_lock_protect flp_lock_protect_i (.clock, .rst_n, .cmd, .cmd_ready,
        .resp, .chk, .chk_ready, .chk_result, .write_enable_latch,
        .wel_clear, .protect_field_bit4(pf[4]), .protect_field_bit3(pf[3]),
        .protect_field_bit2(pf[2]), .protect_field_bit1(pf[1]),
        .protect_field_bit0(pf[0]), .protect_complement(cmpl),
        .register_protect_first(rpf), .write_protect_n(wp_n), .lock_default,
        .factory_init, .status_write_allowed);
    flp_host_model flp_host_model_i (.clock, .cmd_ready, .wel_clear, .cmd,
        .write_enable_latch);

    // Clock
    always #50 clock = ~clock;

    ////////////////////////////////
    function automatic logic [26:0] ad(input int bl, input int s);
        return {bl[10:0], s[3:0], 12'h000};
    endfunction
    task automatic fail(input string m);
        err_total++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic cmp_resp(input logic [10:0] e);
        total_checks++;
        if ({resp.valid, resp.done, resp.refused} !== e[10:8]
            || (resp.valid && resp.data !== e[7:0]))
            fail("command answer");
    endtask
    task automatic cmp_chk(input logic e);
        total_checks++;
        if (chk_result.allowed !== e)
            fail("check verdict");
    endtask
    task automatic op(input logic [7:0] o, input logic [26:0] a,
                      input logic [10:0] e, input logic [7:0] d = 8'h00);
        rq.push_back(e);
        flp_host_model_i.send(o, a, d);
    endtask
    task automatic wop(input logic [7:0] o, input logic [26:0] a,
                       input logic [10:0] e, input logic [7:0] d = 8'h00);
        flp_host_model_i.set_latch(1'b1);
        op(o, a, e, d);
    endtask
    task automatic ck(input flp_chk_kind_t k, input logic [26:0] a,
                      input logic e);
        logic r;
        cq.push_back(e);
        @(posedge clock);
        chk <= '{1'b1, k, a};
        do
        begin
            @(negedge clock);
            r = chk_ready;
            @(posedge clock);
        end
        while (!r);
        chk <= '{1'b0, flp_chk_kind_t'(~k), ~a};
    endtask
    task automatic do_reset(input logic dflt);
        @(posedge clock);
        rst_n <= 1'b0;
        lock_default <= dflt;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
    endtask
    task automatic finish_test;
        if (rq.size() != 0 || cq.size() != 0)
            fail("answers missing");
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Answers compared against the oldest note
    always @(negedge clock)
    begin
        if (rst_n && (resp.valid | resp.done | resp.refused) === 1'b1)
        begin
            if (rq.size() == 0)
                fail("stray answer");
            else
                cmp_resp(rq.pop_front());
        end
        if (rst_n && chk_result.done === 1'b1)
        begin
            if (cq.size() == 0)
                fail("stray verdict");
            else
                cmp_chk(cq.pop_front());
        end
    end

    // Watchdog
    initial
    begin
        #(20000 * 100);
        fail("timeout");
        finish_test();
    end

    ////////////////////////////////
    // Main sequence
    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        lock_default = 1'b1;
        factory_init = 1'b1;
        {cmpl, rpf, wp_n, pf} = 8'h00;
        chk = '0;
        err_total = 0;
        total_checks = 0;
        void'($urandom(32'h5E1B));
        b = $urandom_range(1, 2046);
        bad = 8'($urandom_range(1, 254));
        do_reset(1'b1);
        @(posedge clock);
        factory_init <= 1'b0;
        op(8'hE0, ad(0, 0), ff_e);
        op(8'hE0, ad(2047, 15), ff_e);
        op(8'hE2, ad(b, 0), rd_e);
        wop(8'hE1, ad(b, 0), dn_e, 8'h00);
        op(8'hE0, ad(b, 9), rd_e);
        op(8'hE0, ad(b - 1, 9), ff_e);
        wop(8'hE1, ad(0, 3), rf_e, bad);
        op(8'hE1, ad(0, 3), dn_e, 8'h00);
        op(8'hE0, ad(0, 3), rd_e);
        op(8'hE0, ad(0, 4), ff_e);
        op(8'hE1, ad(0, 4), rf_e, 8'h00);
        op(8'h5A, ad(0, 4), rf_e);
        wop(8'h98, ad(0, 0), dn_e);
        op(8'hE0, ad(2047, 15), rd_e);
        wop(8'h7E, ad(0, 0), dn_e);
        op(8'hE0, ad(b, 0), ff_e);
        ck(FLP_CHK_PROGRAM, ad(b, 0), 1'b0);
        wop(8'h98, ad(0, 0), dn_e);
        rpf <= 1'b1;
        wop(8'hE3, ad(2047, 2), rf_e);
        wp_n <= 1'b1;
        op(8'hE3, ad(2047, 2), dn_e);
        op(8'hE2, ad(2047, 2), ff_e);
        op(8'hE2, ad(2047, 1), rd_e);
        ck(FLP_CHK_PROGRAM, ad(2047, 2), 1'b0);
        ck(FLP_CHK_SECTOR_ERASE, ad(2047, 1), 1'b1);
        ck(FLP_CHK_BLOCK_ERASE, ad(2047, 5), 1'b0);
        ck(FLP_CHK_BLOCK_ERASE, ad(b, 0), 1'b1);
        ck(FLP_CHK_CHIP_ERASE, ad(0, 0), 1'b0);
        do_reset(1'b0);
        op(8'hE0, ad(0, 0), rd_e);
        op(8'hE2, ad(2047, 2), ff_e);
        wop(8'hE4, ad(0, 0), dn_e);
        op(8'hE2, ad(2047, 2), rd_e);
        ck(FLP_CHK_CHIP_ERASE, ad(0, 0), 1'b1);
        cmpl <= 1'b1;
        foreach (rng[i])
        begin
            pf <= rng[i][16:12];
            ck(FLP_CHK_PROGRAM, ad(rng[i][11:1], 0), rng[i][0]);
            @(posedge clock);
        end
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule // tb
`default_nettype wire
